/* File: verification/nv_store_model.sv */
// Model of the stored configuration area beside the test bus selector.
// Assumes one clock and a read that answers one edge after the address.
module nv_store_model
  import test_bus_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       tb_enable,
  input  wire logic [7:0] nv_rf_addr,
  output logic [7:0]      nv_rf_data,
  output logic [7:0]      nv_enable_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////////////////////
  // Only bit 7 enables; the low bits are set so a wrong bit would show.
  assign nv_enable_byte = {tb_enable, 7'h7f};
  // The stored RF sections answer one edge late, as a real array would.
  always_ff @(posedge core_clk) begin
    nv_rf_data <= nv_rf_addr ^ 8'ha5;
  end
endmodule : nv_store_model

/* File: verification/test_bus_signal_select_test.sv */
// Self-checking bench for the debug test bus selector.
// Assumes the design package is compiled first and one 10 MHz clock.
module test_bus_signal_select_test
  import test_bus_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        carrier_clk_pin = 1'b0;
  rx_data_t    rx_data = '0;
  rx_err_t     rx_err = '0;
  logic        tb_enable = 1'b1;
  logic [7:0]  nv_enable_byte;
  logic [7:0]  signal_strength = 8'h0;
  logic [7:0]  filtered_correlation = 8'h0;
  logic [7:0]  nv_rf_data;
  logic [7:0]  nv_rf_addr;
  logic [3:0]  test_pin;
  logic [3:0]  aux_two_sel;
  logic [3:0]  aux_one_sel;
  logic        analog_enable;
  logic        busy;
  logic [7:0]  auto_min_level;
  logic        bit_detect;
  logic        rf_enable;
  logic [31:0] rdata;
  logic        e;
  int          failures = 0;
  int          n_tests = 0;
  logic [12:0] errv [8] = '{13'h1000, 13'h0800, 13'h0400, 13'h031d,
                            13'h031c, 13'h021d, 13'h011d, 13'h1c00};
  ////////////////////////////////////////////////////////////////////////////
  always #50 core_clk = ~core_clk;
  test_bus_signal_select #(.RF_WORDS(2)) dut (
    .core_clk             (core_clk),
    .resetn               (resetn),
    .avs_address          (avs_address),
    .avs_read             (avs_read),
    .avs_write            (avs_write),
    .avs_writedata        (avs_writedata),
    .avs_readdata         (avs_readdata),
    .avs_waitrequest      (avs_waitrequest),
    .carrier_clk_pin      (carrier_clk_pin),
    .rx_data              (rx_data),
    .rx_err               (rx_err),
    .nv_enable_byte       (nv_enable_byte),
    .signal_strength      (signal_strength),
    .filtered_correlation (filtered_correlation),
    .nv_rf_data           (nv_rf_data),
    .nv_rf_addr           (nv_rf_addr),
    .test_pin             (test_pin),
    .aux_two_sel          (aux_two_sel),
    .aux_one_sel          (aux_one_sel),
    .analog_enable        (analog_enable),
    .busy                 (busy),
    .auto_min_level       (auto_min_level),
    .bit_detect           (bit_detect),
    .rf_enable            (rf_enable)
  );
  nv_store_model nv (.core_clk(core_clk), .tb_enable(tb_enable),
    .nv_rf_addr(nv_rf_addr), .nv_rf_data(nv_rf_data),
    .nv_enable_byte(nv_enable_byte));
  ////////////////////////////////////////////////////////////////////////////
  // Every comparison goes through here so the counts stay honest.
  task automatic check(input logic [31:0] seen, exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg,
               seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  // The request is held until the edge that sees waitrequest low; only the
  // watchdog ends a wait that never gets its answer.
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic dig(input logic [7:0] grp, pos);
    bus(1'b1, 4'h0, 32'h18);
    bus(1'b1, 4'h4, {24'h0, grp});
    bus(1'b1, 4'h4, {24'h0, pos});
  endtask : dig
  // What a selected pin should carry, worked out from the group tables.
  function automatic logic pin_exp(logic [7:0] g, logic [3:0] c, int k);
    logic [12:0] v;
    v = errv[k];
    if (c == 4'h8) return k[0];
    if (c > 4'h8) return 1'b0;
    if (g == 8'h70) return k == 7 - c;
    case (c)
      4'h0: return v[12];
      4'h1: return v[11];
      4'h2: return v[10];
      4'h6: return v[9] & v[8] & (v[7:0] > 8'd28);
      4'h7: return |v[12:10];
      default: return 1'b0;
    endcase
  endfunction : pin_exp
  ////////////////////////////////////////////////////////////////////////////
  // A hang counts as a mismatch and still ends through the same verdict.
  initial begin
    tick(30000);
    failures++;
    summarize();
  end
  initial begin
    tick(16);
    resetn <= 1'b1;
    check(test_pin, 4'h0, "reset pins");
    check(aux_two_sel, 4'h8, "reset aux two");
    check(aux_one_sel, 4'h8, "reset aux one");
    check(analog_enable, 1'b0, "reset analog");
    check(rf_enable, 1'b0, "reset rf");
    check(auto_min_level, 8'hff, "reset level");
    $display("test reset done");
    // Walk both groups through codes 0 to 9, some reserved ones included.
    foreach (errv[g]) begin
      if (g > 1) break;
      for (int c = 0; c < 10; c++) begin
        dig(g ? 8'h73 : 8'h70, {4'(c % 4), 4'(c)});
        for (int k = 0; k < 8; k++) begin
          rx_data <= rx_data_t'(8'h01 << k);
          rx_err <= rx_err_t'(errv[k]);
          carrier_clk_pin <= k[0];
          tick(6);
          e = pin_exp(g ? 8'h73 : 8'h70, 4'(c), k);
          check(test_pin[c % 4], e, "digital");
        end
      end
    end
    $display("test digital done");
    // With the stored enable bit clear nothing may reach a pin.
    tb_enable <= 1'b0;
    rx_data <= rx_data_t'(8'hff);
    dig(8'h70, 8'h32);
    tick(4);
    check(test_pin, 4'h0, "disabled pins");
    tb_enable <= 1'b1;
    tick(4);
    check(test_pin[3], 1'b1, "enabled pin");
    $display("test enable done");
    bus(1'b1, 4'h0, 32'h19);
    bus(1'b1, 4'h4, 32'h05);
    bus(1'b1, 4'h4, 32'h0a);
    for (int n = 0; n < 20 && busy !== 1'b1; n++) tick(1);
    check(busy, 1'b1, "busy after analog");
    check(analog_enable, 1'b1, "analog on");
    check(aux_two_sel, 4'h5, "first byte");
    check(aux_one_sel, 4'ha, "second byte");
    bus(1'b0, 4'h8, 32'h0);
    check(rdata[7:0], 8'hb5, "status");
    bus(1'b1, 4'h2, 32'h18);
    bus(1'b0, 4'h2, 32'h0);
    check(rdata, 32'h0, "unmapped read");
    check(aux_two_sel, 4'h5, "held selection");
    $display("test analog done");
    bus(1'b1, 4'h0, 32'h11);
    for (int n = 0; n < 50 && rf_enable !== 1'b1; n++) tick(1);
    check(rf_enable, 1'b1, "rf loaded");
    $display("test rf load done");
    signal_strength <= 8'h64;
    rx_data <= rx_data_t'(8'h20);
    tick(4);
    check(auto_min_level, 8'h32, "half strength");
    filtered_correlation <= 8'h33;
    tick(4);
    check(bit_detect, 1'b1, "above level");
    filtered_correlation <= 8'h32;
    tick(4);
    check(bit_detect, 1'b0, "at level");
    $display("test threshold done");
    summarize();
  end
endmodule : test_bus_signal_select_test

/* File: verilog/test_bus_params.svh */
// Constants for the debug test bus selector.
// Assumes inclusion by bare name from the package and the design module.
`ifndef TEST_BUS_PARAMS_SVH
`define TEST_BUS_PARAMS_SVH
// Register byte offsets on the Avalon-MM slave (word aligned).
`define OFS_CMD          4'h0
`define OFS_PARAM        4'h4
`define OFS_STATUS       4'h8
`define OFS_ENABLE       4'hc
`define OFS_DIG_GROUP    4'h0
// Command codes and group values.
`define CMD_DIGITAL      8'h18
`define CMD_ANALOG       8'h19
`define CMD_RF_LOAD      8'h11
`define GRP_RX_DATA      8'h70
`define GRP_RX_ERROR     8'h73
// Code fields, stored enable location, length limit and sizes.
`define CODE_CARRIER     4'h8
`define CODE_ANA_RSVD    4'h8
`define CODE_ANA_LAST    4'ha
`define NV_ENABLE_ADDR   8'h17
`define NV_ENABLE_BIT    7
`define LEN_LIMIT        8'h1c
`define PIN_COUNT        4
`define RF_WORDS         8
`endif

/* File: verilog/test_bus_pkg.sv */
// Types for the debug test bus selector.
// Assumes the params header sits beside it.
`include "test_bus_params.svh"
package test_bus_pkg;
  // Receiver data-transfer group inputs.
  typedef struct packed {
    logic bit_clk;
    logic chain_reset;
    logic receiving;
    logic rx_active;
    logic sp_data;
    logic sp_valid;
    logic sp_end;
    logic sp_collision;
  } rx_data_t;
  // Receiver error group inputs.
  typedef struct packed {
    logic data_error;
    logic protocol_error;
    logic collision;
    logic multi_frame_receive;
    logic len_valid;
    logic [7:0] frame_length_byte;
  } rx_err_t;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_PARAM = 2'b01,
    ST_LOAD  = 2'b10
  } cmd_state_t;
endpackage : test_bus_pkg

/* File: verilog/test_bus_signal_select.sv */
// Debug test bus selector: digital and analog routing to test pins.
// Assumes synchronous receiver inputs and an Avalon-MM master on core_clk;
// the carrier clock arrives as a pin and is synchronised before use.
// Summary of operation
// - Data group: 0 bit clock, 1 chain reset.
// - Code 2 receiving, code 3 whole reception.
// - Codes 4..7 processor data, valid, end, collision.
// - Code 8 carrier clock; above 8 reserved.
// - Error group: 0 data, 1 protocol, 2 collision.
// - Code 6 long multi-frame length; 3..5 reserved.
// - Code 7 combines data, protocol, collision.
// - Command 0x19 plus two bytes enables analog.
// - First byte aux two, second aux one.
// - Nothing appears unless stored enable active; only test_pin is gated, the analog selections and analog_enable are not.
// - Analog 0..7 DAC, Q, I, filtered, levels.
// - Analog 8 reserved, 9 sum, A presence.
// - Threshold half strength; bit when correlation exceeds.
// - Start-up defaults enable no communication.
// - RF load copies two stored sections.
// - Group 70 data transfer, 73 errors.
// - Position byte: code low, pin high nibble.
// - Enable only when stored byte bit 7 set.
//
// Our own choices: the Avalon-MM interface to the registers and the address map.
`include "test_bus_params.svh"
module test_bus_signal_select
  import test_bus_pkg::*;
#(
  parameter int RF_WORDS = `RF_WORDS
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        carrier_clk_pin,
  input  wire rx_data_t    rx_data,
  input  wire rx_err_t     rx_err,
  input  wire logic [7:0]  nv_enable_byte,
  input  wire logic [7:0]  signal_strength,
  input  wire logic [7:0]  filtered_correlation,
  input  wire logic [7:0]  nv_rf_data,
  output logic [7:0]       nv_rf_addr,
  output logic [`PIN_COUNT-1:0] test_pin,
  output logic [3:0]       aux_two_sel,
  output logic [3:0]       aux_one_sel,
  output logic             analog_enable,
  output logic             busy,
  output logic [7:0]       auto_min_level,
  output logic             bit_detect,
  output logic             rf_enable
);

  // The copy index is seven bits wide, so the area cannot exceed 128 words.
  if (RF_WORDS < 2 || RF_WORDS > 128) begin : g_bad_rf_words
    $error("RF_WORDS out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Carrier clock pin passes two flip-flops before the mux reads it.
  logic carrier_meta;
  logic carrier_sync;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      carrier_meta <= 1'b0;
      carrier_sync <= 1'b0;
    end else begin
      carrier_meta <= carrier_clk_pin;
      carrier_sync <= carrier_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode over the bus: write command, then parameter bytes.
  cmd_state_t      state;
  logic [7:0]      cmd;
  logic [7:0]      group;
  logic [7:0]      pos [`PIN_COUNT];
  logic [2:0]      pcount;
  logic [6:0]      load_idx;
  logic [7:0]      rf_shadow [RF_WORDS];
  logic            wr_cmd;
  logic            wr_par;
  logic            tb_en;

  // Only the first cycle of a request is taken; the master still holds the
  // write in the answer cycle, and taking it again would eat a parameter.
  assign wr_cmd = avs_write && avs_waitrequest && avs_address == `OFS_CMD;
  assign wr_par = avs_write && avs_waitrequest && avs_address == `OFS_PARAM;
  assign tb_en  = nv_enable_byte[`NV_ENABLE_BIT];

  // Command engine; every selection stays until a new command or reset.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state         <= ST_IDLE;
      cmd           <= 8'h00;
      group         <= 8'h00;
      pcount        <= 3'h0;
      aux_two_sel   <= `CODE_ANA_RSVD;
      aux_one_sel   <= `CODE_ANA_RSVD;
      analog_enable <= 1'b0;
      busy          <= 1'b0;
      load_idx      <= 7'h00;
      rf_enable     <= 1'b0;
      nv_rf_addr    <= 8'h00;
      for (int i = 0; i < `PIN_COUNT; i++) begin
        pos[i] <= 8'hff;
      end
    end else begin
      case (state)
        ST_IDLE: begin
          if (wr_cmd) begin
            cmd    <= avs_writedata[7:0];
            pcount <= 3'h0;
            busy   <= 1'b0;
            if (avs_writedata[7:0] == `CMD_RF_LOAD) begin
              state      <= ST_LOAD;
              load_idx   <= 7'h00;
              nv_rf_addr <= 8'h00;
            end else begin
              state <= ST_PARAM;
            end
          end
        end
        ST_PARAM: begin
          if (wr_cmd) begin
            cmd    <= avs_writedata[7:0];
            pcount <= 3'h0;
            busy   <= 1'b0;
            if (avs_writedata[7:0] == `CMD_RF_LOAD) begin
              state      <= ST_LOAD;
              load_idx   <= 7'h00;
              nv_rf_addr <= 8'h00;
            end
          end else if (wr_par && cmd == `CMD_ANALOG) begin
            pcount <= pcount + 3'h1;
            if (pcount == 3'h0) begin
              aux_two_sel <= avs_writedata[3:0];
            end else begin
              aux_one_sel   <= avs_writedata[3:0];
              analog_enable <= 1'b1;
              busy          <= 1'b1;
              state         <= ST_IDLE;
            end
          end else if (wr_par && cmd == `CMD_DIGITAL) begin
            pcount <= pcount + 3'h1;
            if (pcount == 3'h0) begin
              group <= avs_writedata[7:0];
            end else begin
              // Pin nibble picks the slot; codes 4..f name no pin.
              if (avs_writedata[7:4] < 4'(`PIN_COUNT)) begin
                pos[avs_writedata[5:4]] <= avs_writedata[7:0];
              end
              if (pcount == 3'h4) begin
                busy  <= 1'b1;
                state <= ST_IDLE;
              end
            end
          end else if (wr_par) begin
            state <= ST_IDLE; // Unknown command: bytes are dropped.
          end
        end
        ST_LOAD: begin
          // Copies both stored sections word by word into the shadow.
          load_idx   <= load_idx + 7'h01;
          nv_rf_addr <= nv_rf_addr + 8'h01;
          if (load_idx == 7'(RF_WORDS - 1)) begin
            rf_enable <= 1'b1;
            busy      <= 1'b1;
            state     <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Shadow of the RF registers; cleared at reset so nothing radiates.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < RF_WORDS; i++) begin
        rf_shadow[i] <= 8'h00;
      end
    end else if (state == ST_LOAD) begin
      rf_shadow[load_idx[$clog2(RF_WORDS)-1:0]] <= nv_rf_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin digital mux; code 8 gives the carrier in any group, other reserved codes and other groups read low.
  logic [`PIN_COUNT-1:0] next_pin;
  genvar g;
  generate
    for (g = 0; g < `PIN_COUNT; g++) begin : g_pin
      logic s;
      always_comb begin
        s = 1'b0;
        if (pos[g][3:0] == `CODE_CARRIER) begin
          s = carrier_sync;
        end else if (group == `GRP_RX_DATA) begin
          case (pos[g][3:0])
            4'h0:    s = rx_data.bit_clk;
            4'h1:    s = rx_data.chain_reset;
            4'h2:    s = rx_data.receiving;
            4'h3:    s = rx_data.rx_active;
            4'h4:    s = rx_data.sp_data;
            4'h5:    s = rx_data.sp_valid;
            4'h6:    s = rx_data.sp_end;
            4'h7:    s = rx_data.sp_collision;
            default: s = 1'b0;
          endcase
        end else if (group == `GRP_RX_ERROR) begin
          case (pos[g][3:0])
            4'h0:    s = rx_err.data_error;
            4'h1:    s = rx_err.protocol_error;
            4'h2:    s = rx_err.collision;
            4'h6:    s = rx_err.multi_frame_receive && rx_err.len_valid
                         && rx_err.frame_length_byte > `LEN_LIMIT;
            4'h7:    s = rx_err.data_error | rx_err.protocol_error
                         | rx_err.collision;
            default: s = 1'b0;
          endcase
        end
      end
      assign next_pin[g] = s && tb_en;
    end
  endgenerate

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      test_pin <= '0;
    end else begin
      test_pin <= next_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Automatic minimum level: half the measured strength after start bit.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      auto_min_level <= 8'hff;
      bit_detect     <= 1'b0;
    end else begin
      if (rx_data.chain_reset) begin
        auto_min_level <= 8'hff;
      end else if (rx_data.receiving) begin
        auto_min_level <= {1'b0, signal_strength[7:1]};
      end
      bit_detect <= filtered_correlation > auto_min_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: reads registered, one cycle of waitrequest on every access.
  logic [31:0] next_rdata;
  always_comb begin
    case (avs_address)
      `OFS_CMD:    next_rdata = {24'h000000, cmd};
      `OFS_PARAM:  next_rdata = {24'h000000, group};
      `OFS_STATUS: next_rdata = {24'h000000, analog_enable, rf_enable,
                                 busy, tb_en, aux_two_sel};
      `OFS_ENABLE: next_rdata = {20'h00000, aux_one_sel,
                                 4'h0, 4'(test_pin)};
      default:     next_rdata = 32'h00000000;
    endcase
  end

  // Every access waits one cycle; read data land with waitrequest low.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_ENABLE_GATE: assert property (
    @(posedge core_clk) disable iff (!resetn)
    !tb_en |=> test_pin == '0)
    else $error("test pin active while bus disabled");
  AST_ANALOG_ORDER: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (state == ST_PARAM && cmd == `CMD_ANALOG && wr_par && pcount == 3'h1
     && !wr_cmd) |=> analog_enable && busy && aux_one_sel
     == $past(avs_writedata[3:0]))
    else $error("analog command not taken");
  AST_AUX_TWO: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (state == ST_PARAM && cmd == `CMD_ANALOG && wr_par && pcount == 3'h0
     && !wr_cmd) |=> aux_two_sel == $past(avs_writedata[3:0]))
    else $error("first analog byte misrouted");
  AST_THRESHOLD: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (rx_data.receiving && !rx_data.chain_reset) |=>
      auto_min_level == {1'b0, $past(signal_strength[7:1])})
    else $error("threshold not half strength");
  AST_BIT_DETECT: assert property (
    @(posedge core_clk) disable iff (!resetn)
    bit_detect == $past(filtered_correlation > auto_min_level))
    else $error("bit detect mismatch");
  AST_RF_LOAD: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (state == ST_IDLE && wr_cmd && avs_writedata[7:0] == `CMD_RF_LOAD)
      |=> state == ST_LOAD ##RF_WORDS rf_enable && state == ST_IDLE)
    else $error("rf load length wrong");
  AST_HOLD: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (!avs_write && state != ST_LOAD) |=> $stable(group)
      && $stable(aux_one_sel) && $stable(aux_two_sel))
    else $error("selection changed without command");
  AST_WAIT: assert property (@(posedge core_clk) disable iff (!resetn)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("slave did not answer");

endmodule : test_bus_signal_select
